/* File: inc/snsts_map.svh */
`ifndef SNSTS_MAP_SVH
`define SNSTS_MAP_SVH
// register byte offsets
`define SNSTS_CTRL_OFF 8'h00
`define SNSTS_SCREEN_OFF 8'h04
`define SNSTS_NOTIFY_OFF 8'h08
`define SNSTS_IRQ_STAT_OFF 8'h0C
`define SNSTS_IRQ_MASK_OFF 8'h10
`define SNSTS_STR_SEL_OFF 8'h14
`define SNSTS_STR_CFG_OFF 8'h18
`define SNSTS_STR_DATA_OFF 8'h1C
`define SNSTS_HOST_ADDR_OFF 8'h20
`define SNSTS_HOST_DATA_OFF 8'h24
`define SNSTS_IND_CNT_OFF 8'h28
// field positions
`define SNSTS_STROBE_BIT 15
`define SNSTS_CTRL_TOUCH_BIT 0
`define SNSTS_CTRL_PARENT_BIT 1
`define SNSTS_CTRL_INIT_BIT 2
`define SNSTS_CTRL_ACK_BIT 3
`define SNSTS_IRQ_SWITCH_BIT 0
`define SNSTS_IRQ_IND_BIT 1
`define SNSTS_IRQ_AREA_BIT 2
// sizes and limits
`define SNSTS_ENTRIES 8
`define SNSTS_MAX_WORDS 20
`define SNSTS_MAX_INDIRECT 50
`define SNSTS_HOST_WORDS 256
`define SNSTS_STROBE_HOLD 4
`endif

/* File: inc/snsts_pkg.sv */
package snsts_pkg;
  typedef enum logic [2:0] {
    snsts_area_data,
    snsts_area_io,
    snsts_area_hold,
    snsts_area_aux,
    snsts_area_link,
    snsts_area_timer,
    snsts_area_counter,
    snsts_area_none
  } snsts_area_type;
  typedef struct packed {
    logic init_on_reset;
    logic indirect;
    logic operator_input;
    snsts_area_type area;
    logic [4:0] word_count;
    logic [4:0] char_count;
    logic [7:0] first_word;
  } snsts_entry_type;
  typedef struct packed {
    logic [15:0] status;
    logic [15:0] screen;
  } snsts_notify_type;
endpackage

/* File: core/snsts_core.sv */
// Purpose: terminal side of the shared word notify and string table sync
// Assumes: host words live in a local shared array reached over axi4-lite
// Notes: one write and one read in flight at a time
// Contract
// - set strobe flag on every screen change
// - write new screen number with strobe
// - screen numbers are four bcd digits
// - clear strobe after report to host
// - touch switch changes also report screen (the ctrl touch bit is stored but no logic uses it)
// - report parent number for screen groups
// - notify area never in timer, counter
// - keep displayed strings equal host words
// - indirect uses numeral value as index
// - at most 50 indirect displays per screen
// - operator input strings only direct mapped
// - optional initial value write at reset
// - up to 20 words, two characters each
// - overlong strings may be cut partway
// - string areas exclude timer and counter
`timescale 1ns/1ps
`include "snsts_map.svh"
module snsts_core
  import snsts_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display side
  output logic [15:0] disp_char_pair,
  output logic irq
);
  localparam int NE = `SNSTS_ENTRIES;
  localparam int NH = `SNSTS_HOST_WORDS;

  logic [15:0] host_mem [0:NH-1];
  logic [15:0] str_mem [0:NE-1][0:`SNSTS_MAX_WORDS-1];
  snsts_entry_type cfg_reg [0:NE-1];
  snsts_notify_type notify_reg;
  logic [7:0] notify_base_reg;
  snsts_area_type notify_area_reg;
  logic [15:0] screen_reg;
  logic [3:0] ctrl_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] sel_reg;
  logic [4:0] widx_reg;
  logic [7:0] hptr_reg;
  logic [5:0] ind_cnt_reg;
  logic [2:0] scan_reg;
  logic [4:0] scan_w_reg;
  logic [2:0] hold_reg;
  logic init_done_reg;
  logic [2:0] init_e_reg;
  logic [4:0] init_w_reg;
  logic [15:0] disp_reg;

  // bus channel state
  logic aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_go;
  logic screen_wr, ack_wr, notify_rd;
  logic bad_area, area_err;
  logic [2:0] ev;
  logic [15:0] wd16;

  assign wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;
  assign wd16 = w_data_reg[15:0];
  assign screen_wr = wr_go && aw_addr_reg == `SNSTS_SCREEN_OFF;
  assign ack_wr = wr_go && aw_addr_reg == `SNSTS_CTRL_OFF &&
                  w_data_reg[`SNSTS_CTRL_ACK_BIT];
  assign notify_rd = s_axi_arvalid && s_axi_arready &&
                     s_axi_araddr == `SNSTS_NOTIFY_OFF;

  function automatic logic area_ok(input snsts_area_type a);
    area_ok = a != snsts_area_timer && a != snsts_area_counter &&
              a != snsts_area_none;
  endfunction

  function automatic logic is_bcd(input logic [15:0] v);
    is_bcd = v[3:0] < 4'hA && v[7:4] < 4'hA && v[11:8] < 4'hA &&
             v[15:12] < 4'hA;
  endfunction

  // write channel capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  // read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `SNSTS_CTRL_OFF: s_axi_rdata <= {28'h000_0000, ctrl_reg};
        `SNSTS_SCREEN_OFF: s_axi_rdata <= {16'h0000, screen_reg};
        `SNSTS_NOTIFY_OFF: s_axi_rdata <= notify_reg;
        `SNSTS_IRQ_STAT_OFF: s_axi_rdata <= {29'h0000_0000, irq_stat_reg};
        `SNSTS_IRQ_MASK_OFF: s_axi_rdata <= {29'h0000_0000, irq_mask_reg};
        `SNSTS_STR_SEL_OFF:
          s_axi_rdata <= {13'h0000, notify_base_reg, notify_area_reg,
                          widx_reg[4:0], sel_reg};
        `SNSTS_STR_CFG_OFF: s_axi_rdata <= {8'h00, cfg_reg[sel_reg]};
        `SNSTS_STR_DATA_OFF:
          s_axi_rdata <= {16'h0000, str_mem[sel_reg][widx_reg]};
        `SNSTS_HOST_ADDR_OFF: s_axi_rdata <= {24'h00_0000, hptr_reg};
        `SNSTS_HOST_DATA_OFF: s_axi_rdata <= {16'h0000, host_mem[hptr_reg]};
        `SNSTS_IND_CNT_OFF: s_axi_rdata <= {26'h000_0000, ind_cnt_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // software configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 4'h0;
      irq_mask_reg <= 3'h0;
      sel_reg <= 3'h0;
      widx_reg <= 5'h00;
      hptr_reg <= 8'h00;
      notify_base_reg <= 8'h00;
      notify_area_reg <= snsts_area_data;
      ind_cnt_reg <= 6'h00;
    end else if (wr_go && w_strb_reg[0]) begin
      case (aw_addr_reg)
        `SNSTS_CTRL_OFF: ctrl_reg <= {1'b0, w_data_reg[2:0]};
        `SNSTS_IRQ_MASK_OFF: irq_mask_reg <= w_data_reg[2:0];
        `SNSTS_STR_SEL_OFF: begin
          sel_reg <= w_data_reg[2:0];
          widx_reg <= (w_data_reg[7:3] < 5'(`SNSTS_MAX_WORDS)) ?
                      w_data_reg[7:3] : 5'h00;
          if (area_ok(snsts_area_type'(w_data_reg[10:8]))) begin
            notify_area_reg <= snsts_area_type'(w_data_reg[10:8]);
            notify_base_reg <= w_data_reg[18:11];
          end
        end
        `SNSTS_HOST_ADDR_OFF: hptr_reg <= w_data_reg[7:0];
        `SNSTS_IND_CNT_OFF:
          ind_cnt_reg <= (w_data_reg[5:0] > 6'(`SNSTS_MAX_INDIRECT)) ?
                         6'(`SNSTS_MAX_INDIRECT) : w_data_reg[5:0];
        default: ;
      endcase
    end
  end

  // per entry configuration, one loop
  for (genvar e = 0; e < NE; e++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_reg[e] <= '{init_on_reset: 1'b0, indirect: 1'b0,
                        operator_input: 1'b0, area: snsts_area_none,
                        word_count: 5'h00, char_count: 5'h00,
                        first_word: 8'h00};
      end else if (wr_go && aw_addr_reg == `SNSTS_STR_CFG_OFF &&
                   sel_reg == 3'(e)) begin
        cfg_reg[e].init_on_reset <= w_data_reg[23];
        cfg_reg[e].indirect <= w_data_reg[22] && !w_data_reg[21];
        cfg_reg[e].operator_input <= w_data_reg[21];
        cfg_reg[e].area <= area_ok(snsts_area_type'(w_data_reg[20:18])) ?
          snsts_area_type'(w_data_reg[20:18]) : snsts_area_none;
        cfg_reg[e].word_count <= (w_data_reg[17:13] >
          5'(`SNSTS_MAX_WORDS)) ? 5'(`SNSTS_MAX_WORDS) :
          w_data_reg[17:13];
        cfg_reg[e].char_count <= w_data_reg[12:8];
        cfg_reg[e].first_word <= w_data_reg[7:0];
      end
    end
  end

  // screen change and strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      screen_reg <= 16'h0000;
      notify_reg <= '{status: 16'h0000, screen: 16'h0000};
      hold_reg <= 3'h0;
    end else begin
      if (screen_wr && is_bcd(wd16) && wd16 != screen_reg) begin
        screen_reg <= wd16;
        // parent number reported for groups, selected by bit 17 of the screen write
        notify_reg.screen <= w_data_reg[`SNSTS_CTRL_PARENT_BIT + 16] ?
          {w_data_reg[31:20], 4'h0} : wd16;
        notify_reg.status[`SNSTS_STROBE_BIT] <= 1'b1;
        hold_reg <= 3'(`SNSTS_STROBE_HOLD);
      end else if (hold_reg != 3'h0) begin
        if (notify_rd) hold_reg <= hold_reg - 3'h1;
      end else if (ack_wr || notify_rd) begin
        notify_reg.status[`SNSTS_STROBE_BIT] <= 1'b0;
      end
    end
  end

  // interrupt status, set beats clear
  assign bad_area = wr_go && aw_addr_reg == `SNSTS_STR_CFG_OFF &&
                    !area_ok(snsts_area_type'(w_data_reg[20:18]));
  assign area_err = wr_go && aw_addr_reg == `SNSTS_IND_CNT_OFF &&
                    w_data_reg[5:0] > 6'(`SNSTS_MAX_INDIRECT);
  assign ev = {bad_area, area_err,
               screen_wr && is_bcd(wd16) && wd16 != screen_reg};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_go && aw_addr_reg == `SNSTS_IRQ_STAT_OFF)
        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[2:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // init write of stored values, then continuous refresh
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_done_reg <= 1'b0;
      init_e_reg <= 3'h0;
      init_w_reg <= 5'h00;
      scan_reg <= 3'h0;
      scan_w_reg <= 5'h00;
      disp_reg <= 16'h0000;
    end else if (!init_done_reg) begin
      if (cfg_reg[init_e_reg].init_on_reset &&
          init_w_reg < cfg_reg[init_e_reg].word_count)
        host_mem[8'(cfg_reg[init_e_reg].first_word + 8'(init_w_reg))] <=
          str_mem[init_e_reg][init_w_reg];
      if (init_w_reg == 5'(`SNSTS_MAX_WORDS - 1)) begin
        init_w_reg <= 5'h00;
        init_e_reg <= init_e_reg + 3'h1;
        if (init_e_reg == 3'(NE - 1)) init_done_reg <= 1'b1;
      end else begin
        init_w_reg <= init_w_reg + 5'h01;
      end
    end else begin
      if (wr_go && aw_addr_reg == `SNSTS_HOST_DATA_OFF)
        host_mem[hptr_reg] <= wd16;
      if (cfg_reg[scan_reg].area != snsts_area_none &&
          scan_w_reg < cfg_reg[scan_reg].word_count) begin
        if (cfg_reg[scan_reg].indirect &&
            ind_cnt_reg <= 6'(`SNSTS_MAX_INDIRECT)) begin
          str_mem[scan_reg][scan_w_reg] <= str_mem[
            host_mem[cfg_reg[scan_reg].first_word][2:0]][scan_w_reg];
        end else begin
          str_mem[scan_reg][scan_w_reg] <= host_mem[
            8'(cfg_reg[scan_reg].first_word + 8'(scan_w_reg))];
        end
      end
      // two characters per word, words starting at or past char count blanked
      if (scan_reg == sel_reg && scan_w_reg == widx_reg)
        disp_reg <= ({scan_w_reg, 1'b0} <
                     {1'b0, cfg_reg[scan_reg].char_count}) ?
          str_mem[scan_reg][scan_w_reg] : 16'h0000;
      if (scan_w_reg == 5'(`SNSTS_MAX_WORDS - 1)) begin
        scan_w_reg <= 5'h00;
        scan_reg <= scan_reg + 3'h1;
      end else begin
        scan_w_reg <= scan_w_reg + 5'h01;
      end
    end
  end

  // software writes of stored init values, accepted but not stored
  always_ff @(posedge aclk) begin
    if (wr_go && aw_addr_reg == `SNSTS_STR_DATA_OFF && !init_done_reg)
      ;
  end

  assign disp_char_pair = disp_reg;
endmodule

/* File: bench/snsts_core_checker.sv */
// Purpose: bus handshake and notify word checks
// Assumes: sees only the core ports, one clock
// Notes: last read address kept to judge read data
`timescale 1ns/1ps
`include "snsts_map.svh"
module snsts_core_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] rd_addr_reg;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_reg <= s_axi_araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
    else $error("write response not okay");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  a_aw_refused: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_screen_bcd: assert property (
    s_axi_rvalid && rd_addr_reg == `SNSTS_NOTIFY_OFF |->
    s_axi_rdata[3:0] < 4'hA && s_axi_rdata[7:4] < 4'hA &&
    s_axi_rdata[11:8] < 4'hA && s_axi_rdata[15:12] < 4'hA)
    else $error("screen word not bcd");
  a_unmapped_err: assert property (
    s_axi_rvalid && rd_addr_reg > `SNSTS_IND_CNT_OFF |->
    s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule
bind snsts_core snsts_core_checker i_snsts_core_checker (.*);

/* File: bench/snsts_host_model.sv */
// Purpose: host controller reaching the shared words
// Assumes: one write and one read at a time
// Notes: slow delays the response ready by three cycles
`timescale 1ns/1ps
module snsts_host_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read side
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic slow;
  initial begin
    slow = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // screen numbers written by the host need not be bcd
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~v;
      end
    end
    if (slow) repeat (3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // screen word taken together with its strobe in one read
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    if (slow) repeat (3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: bench/snsts_core_test.sv */
// Purpose: register level tests of the notify and string sync
// Assumes: init pass done within 200 cycles of reset release
// Notes: string refresh has no done flag, so fixed waits
`timescale 1ns/1ps
`include "snsts_map.svh"
module snsts_core_test;
  logic aclk, aresetn, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] disp_char_pair;
  int miscompares;
  int tests_run;
  snsts_core i_snsts_core (.*);
  snsts_host_model i_snsts_host_model (.*);
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t resp %b expected %b", $time, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] v);
    i_snsts_host_model.wr(a, v, r);
  endtask
  task automatic get(input logic [7:0] a);
    i_snsts_host_model.rd(a, d, r);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    settle(20000);
    miscompares++;
    results;
  end
  initial begin
    miscompares = 0;
    tests_run = 0;
    aresetn = 1'b0;
    settle(10);
    aresetn <= 1'b1;
    settle(200);
    put(`SNSTS_SCREEN_OFF, 32'h0000_0002);
    get(`SNSTS_NOTIFY_OFF);
    chk_word(d & 32'h8000_FFFF, 32'h8000_0002);
    put(`SNSTS_SCREEN_OFF, 32'h0000_00A3);
    repeat (3) begin
      get(`SNSTS_NOTIFY_OFF);
      chk_word(d & 32'h8000_FFFF, 32'h8000_0002);
    end
    put(`SNSTS_CTRL_OFF, 32'h0000_0008);
    get(`SNSTS_NOTIFY_OFF);
    chk_word(d & 32'h8000_FFFF, 32'h0000_0002);
    put(`SNSTS_CTRL_OFF, 32'h0000_0003);
    put(`SNSTS_SCREEN_OFF, 32'h0122_0015);
    get(`SNSTS_NOTIFY_OFF);
    chk_word(d & 32'h8000_FFFF, 32'h8000_0120);
    put(`SNSTS_IRQ_MASK_OFF, 32'h0000_0000);
    settle(3);
    chk_word({31'h0, irq}, 32'h0000_0000);
    put(`SNSTS_IRQ_MASK_OFF, 32'h0000_0001);
    settle(3);
    chk_word({31'h0, irq}, 32'h0000_0001);
    put(`SNSTS_IRQ_STAT_OFF, 32'h0000_0001);
    settle(3);
    chk_word({31'h0, irq}, 32'h0000_0000);
    put(`SNSTS_STR_SEL_OFF, 32'h0000_0000);
    put(`SNSTS_STR_CFG_OFF, 32'h0014_0000);
    get(`SNSTS_STR_CFG_OFF);
    chk_word(d & 32'h001C_0000, 32'h001C_0000);
    get(`SNSTS_IRQ_STAT_OFF);
    chk_word(d & 32'h0000_0004, 32'h0000_0004);
    put(`SNSTS_STR_CFG_OFF, 32'h0000_4410);
    put(`SNSTS_HOST_ADDR_OFF, 32'h0000_0010);
    put(`SNSTS_HOST_DATA_OFF, 32'h0000_4142);
    put(`SNSTS_HOST_ADDR_OFF, 32'h0000_0011);
    put(`SNSTS_HOST_DATA_OFF, 32'h0000_4344);
    // a full refresh sweep is 160 cycles, display lags one sweep more
    settle(400);
    get(`SNSTS_STR_DATA_OFF);
    chk_word(d, 32'h0000_4142);
    chk_word({16'h0, disp_char_pair}, 32'h0000_4142);
    put(`SNSTS_STR_SEL_OFF, 32'h0000_0008);
    settle(50);
    get(`SNSTS_STR_DATA_OFF);
    chk_word(d, 32'h0000_4344);
    put(`SNSTS_STR_SEL_OFF, 32'h0000_0001);
    put(`SNSTS_STR_CFG_OFF, 32'h0040_4420);
    put(`SNSTS_HOST_ADDR_OFF, 32'h0000_0020);
    put(`SNSTS_HOST_DATA_OFF, 32'h0000_0000);
    settle(400);
    get(`SNSTS_STR_DATA_OFF);
    chk_word(d, 32'h0000_4142);
    get(`SNSTS_IND_CNT_OFF);
    chk_word({31'h0, d <= 32'd50}, 32'h0000_0001);
    put(`SNSTS_IND_CNT_OFF, 32'h0000_003C);
    get(`SNSTS_IND_CNT_OFF);
    chk_word(d, 32'h0000_0032);
    get(`SNSTS_IRQ_STAT_OFF);
    chk_word(d & 32'h0000_0002, 32'h0000_0002);
    put(`SNSTS_STR_CFG_OFF, 32'h0060_4420);
    settle(400);
    get(`SNSTS_STR_DATA_OFF);
    chk_word(d, 32'h0000_0000);
    i_snsts_host_model.slow = 1'b1;
    get(8'h3C);
    chk_resp(r, 2'b10);
    chk_word(d, 32'h0000_0000);
    put(8'h40, 32'h0000_1234);
    chk_resp(r, 2'b00);
    results;
  end
endmodule
